// ===== rtl/counter_array_capture_pwm.sv
`timescale 1ns/10ps
// Behaviour
// - Tick source: 00 osc/12, 01 osc/4, 10 timer 0 overflow, 11 count pin.
// - Idle-stop set halts counter while processor idles; clear keeps it running.
// - Watchdog-enable bit turns watchdog function on or off, in module 4.
// - Counter overflow sets overflow flag; interrupt if overflow interrupt enabled.
// - Counter advances only while run bit is set.
// - Overflow flag is cleared only by a software write.
// - Match or capture sets module event flag; only software clears it.
// - Set module event flag interrupts when module interrupt enable is set.
// - Toggle bit inverts module pin when counter equals compare value.
// - Match bit makes counter-compare equality set the module event flag.
// - Mode bit 4 captures falling edges, bit 5 rising; both means either.
// - Mode bit 6 enables the counter-versus-compare comparator.
// - Mode bit 1 enables pulse width modulation.
// - Enabled pin transition copies 16-bit counter into capture registers.
// - Compare plus match gives a software timer with event flag.
// - Toggle, match and compare together give a high-speed output.
// - Modulation output is low while counter low below capture low, else high.
// - Counter low wrap FF to 00 reloads capture low from capture high.
module counter_array_capture_pwm #(
   parameter int COUNT_WIDTH = 16
) (
   input wire logic CLK,
   input wire logic ARST_N,
   // Special-function register port
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   output logic [7:0] SFR_RDATA,
   // System status
   input wire logic CPU_IDLE,
   input wire logic TIMER0_OVERFLOW,
   // Pins
   input wire logic COUNT_INPUT_PIN,
   input wire logic MODULE_PIN_IN,
   output logic MODULE_PIN_OUT,
   output logic MODULE_PIN_OE,
   // Status outputs
   output logic IRQ,
   output logic WATCHDOG_ACTIVE
);

   localparam int HALF = COUNT_WIDTH / 2;

   logic [7:0] counter_mode_reg;
   logic [7:0] counter_control_reg;
   logic [7:0] module_mode_reg;
   logic [COUNT_WIDTH-1:0] counter_reg;
   logic [COUNT_WIDTH-1:0] counter_next;
   logic [COUNT_WIDTH-1:0] capture_reg;
   logic [COUNT_WIDTH-1:0] capture_next;
   logic overflow_flag_next;
   logic event_flag_next;
   logic pin_out_reg;
   logic pin_out_next;
   logic [7:0] rdata_next;
   logic irq_next;

   logic tick_div12;
   logic tick_div4;
   logic pin_rise;
   logic pin_fall;
   logic count_rise;

   // ***********************************************
   // Tick generation and pin conditioning
   // ***********************************************
   tick_prescaler u_prescaler (
      .clk(CLK),
      .arst_n(ARST_N),
      .tick_div12(tick_div12),
      .tick_div4(tick_div4)
   );

   // Count pin through synchroniser; rising edge counts
   pin_edge_detect u_count_pin (
      .clk(CLK),
      .arst_n(ARST_N),
      .pin_in(COUNT_INPUT_PIN),
      .level(),
      .rise(count_rise),
      .fall()
   );

   // Module pin through synchroniser for capture
   pin_edge_detect u_module_pin (
      .clk(CLK),
      .arst_n(ARST_N),
      .pin_in(MODULE_PIN_IN),
      .level(),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ***********************************************
   // Field decode
   // ***********************************************
   wire idle_stop = counter_mode_reg[counter_array_pkg::IDLE_STOP_BIT];
   wire watchdog_enable =
      counter_mode_reg[counter_array_pkg::WATCHDOG_ENABLE_BIT];
   wire tick_select_hi = counter_mode_reg[counter_array_pkg::TICK_SELECT_HI_BIT];
   wire tick_select_lo = counter_mode_reg[counter_array_pkg::TICK_SELECT_LO_BIT];
   wire overflow_irq_enable =
      counter_mode_reg[counter_array_pkg::OVERFLOW_IRQ_ENABLE_BIT];
   wire overflow_flag =
      counter_control_reg[counter_array_pkg::OVERFLOW_FLAG_BIT];
   wire run_bit = counter_control_reg[counter_array_pkg::RUN_BIT];
   wire module_event_flag =
      counter_control_reg[counter_array_pkg::MODULE_EVENT_FLAG_BIT];
   wire compare_enable = module_mode_reg[counter_array_pkg::COMPARE_ENABLE_BIT];
   wire capture_rising = module_mode_reg[counter_array_pkg::CAPTURE_RISING_BIT];
   wire capture_falling =
      module_mode_reg[counter_array_pkg::CAPTURE_FALLING_BIT];
   wire match_flag_enable =
      module_mode_reg[counter_array_pkg::MATCH_FLAG_ENABLE_BIT];
   wire toggle_enable = module_mode_reg[counter_array_pkg::TOGGLE_ENABLE_BIT];
   wire pwm_enable = module_mode_reg[counter_array_pkg::PWM_ENABLE_BIT];
   wire module_irq_enable =
      module_mode_reg[counter_array_pkg::MODULE_IRQ_ENABLE_BIT];

   // Register write strobes
   wire wr_mode = SFR_WR && (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_MODE);
   wire wr_ctrl = SFR_WR &&
                  (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_CONTROL);
   wire wr_mmode = SFR_WR && (SFR_ADDR == counter_array_pkg::ADDR_MODULE_MODE);
   wire wr_cnt_hi = SFR_WR && (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_HIGH);
   wire wr_cnt_lo = SFR_WR && (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_LOW);
   wire wr_cap_hi = SFR_WR && (SFR_ADDR == counter_array_pkg::ADDR_CAPTURE_HIGH);
   wire wr_cap_lo = SFR_WR && (SFR_ADDR == counter_array_pkg::ADDR_CAPTURE_LOW);

   // ***********************************************
   // Counter tick selection and advance
   // ***********************************************
   counter_array_pkg::tick_source_t tick_source;
   assign tick_source =
      counter_array_pkg::tick_source_t'({tick_select_hi, tick_select_lo});

   // Source multiplexer
   wire source_tick =
      (tick_source == counter_array_pkg::TICK_DIV12) ? tick_div12 :
      (tick_source == counter_array_pkg::TICK_DIV4) ? tick_div4 :
      (tick_source == counter_array_pkg::TICK_TIMER0) ? TIMER0_OVERFLOW :
      count_rise;

   // Gate by run bit and idle stop
   wire idle_halt = idle_stop & CPU_IDLE;
   wire count_tick = source_tick & run_bit & ~idle_halt;

   // Overflow when the counter wraps from all ones
   wire counter_all_ones = &counter_reg;
   wire overflow_event = count_tick & counter_all_ones;
   wire low_wrap = count_tick &
                   (counter_reg[HALF-1:0] ==
                    counter_array_pkg::LOW_BYTE_ALL_ONES);

   // ***********************************************
   // Module compare and capture
   // ***********************************************
   // Comparator sees the live counter against the compare registers
   wire counter_equal = (counter_reg == capture_reg);
   wire match_event = compare_enable & counter_equal & count_tick;
   wire capture_event = (capture_falling & pin_fall) |
                        (capture_rising & pin_rise);
   wire pwm_mode = pwm_enable & compare_enable;
   wire flag_on_match = match_event & match_flag_enable & ~pwm_mode;
   wire toggle_event = match_event & toggle_enable & ~pwm_mode;

   // Duty compare on low bytes
   wire pwm_level = (counter_reg[HALF-1:0] >= capture_reg[HALF-1:0]);

   // ***********************************************
   // Next-state selection
   // ***********************************************
   // Counter: software write beats tick
   assign counter_next =
      wr_cnt_hi ? {SFR_WDATA, counter_reg[HALF-1:0]} :
      wr_cnt_lo ? {counter_reg[COUNT_WIDTH-1:HALF], SFR_WDATA} :
      count_tick ? counter_reg + 1'b1 : counter_reg;

   // Capture registers: capture, then modulation reload, then software
   assign capture_next =
      capture_event ? counter_reg :
      (pwm_mode && low_wrap) ?
         {capture_reg[COUNT_WIDTH-1:HALF],
          capture_reg[COUNT_WIDTH-1:HALF]} :
      wr_cap_hi ? {SFR_WDATA, capture_reg[HALF-1:0]} :
      wr_cap_lo ? {capture_reg[COUNT_WIDTH-1:HALF], SFR_WDATA} :
      capture_reg;

   // Flags: a hardware set wins over a software clear
   assign overflow_flag_next = overflow_event |
      (wr_ctrl ? SFR_WDATA[counter_array_pkg::OVERFLOW_FLAG_BIT] :
                 overflow_flag);
   assign event_flag_next = flag_on_match | capture_event |
      (wr_ctrl ? SFR_WDATA[counter_array_pkg::MODULE_EVENT_FLAG_BIT] :
                 module_event_flag);

   // Module pin: modulation level or high-speed toggle
   assign pin_out_next = pwm_mode ? pwm_level :
                         toggle_event ? ~pin_out_reg : pin_out_reg;

   // Interrupt from either flag with its enable
   assign irq_next = (overflow_flag_next & overflow_irq_enable) |
                     (event_flag_next & module_irq_enable);

   // Read multiplexer
   assign rdata_next =
      (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_MODE) ? counter_mode_reg :
      (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_CONTROL) ?
         counter_control_reg :
      (SFR_ADDR == counter_array_pkg::ADDR_MODULE_MODE) ? module_mode_reg :
      (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_HIGH) ?
         counter_reg[COUNT_WIDTH-1:HALF] :
      (SFR_ADDR == counter_array_pkg::ADDR_COUNTER_LOW) ?
         counter_reg[HALF-1:0] :
      (SFR_ADDR == counter_array_pkg::ADDR_CAPTURE_HIGH) ?
         capture_reg[COUNT_WIDTH-1:HALF] :
      (SFR_ADDR == counter_array_pkg::ADDR_CAPTURE_LOW) ?
         capture_reg[HALF-1:0] : 8'h00;

   // ***********************************************
   // Configuration registers
   // ***********************************************
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         counter_mode_reg <= counter_array_pkg::COUNTER_MODE_RESET;
         module_mode_reg <= counter_array_pkg::MODULE_MODE_RESET;
      end else begin
         if (wr_mode) begin
            counter_mode_reg <= SFR_WDATA & counter_array_pkg::COUNTER_MODE_MASK;
         end
         if (wr_mmode) begin
            module_mode_reg <= SFR_WDATA & counter_array_pkg::MODULE_MODE_MASK;
         end
      end
   end

   // Control register: run bit from software, flags merged
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         counter_control_reg <= counter_array_pkg::COUNTER_CONTROL_RESET;
      end else begin
         counter_control_reg[counter_array_pkg::OVERFLOW_FLAG_BIT] <=
            overflow_flag_next;
         counter_control_reg[counter_array_pkg::MODULE_EVENT_FLAG_BIT] <=
            event_flag_next;
         if (wr_ctrl) begin
            counter_control_reg[counter_array_pkg::RUN_BIT] <=
               SFR_WDATA[counter_array_pkg::RUN_BIT];
         end
      end
   end

   // ***********************************************
   // Counter, capture and output flops
   // ***********************************************
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         counter_reg <= counter_array_pkg::COUNTER_RESET;
         capture_reg <= counter_array_pkg::CAPTURE_RESET;
         pin_out_reg <= 1'b0;
         SFR_RDATA <= 8'h00;
         IRQ <= 1'b0;
         WATCHDOG_ACTIVE <= 1'b0;
         MODULE_PIN_OE <= 1'b0;
      end else begin
         counter_reg <= counter_next;
         capture_reg <= capture_next;
         pin_out_reg <= pin_out_next;
         SFR_RDATA <= rdata_next;
         IRQ <= irq_next;
         WATCHDOG_ACTIVE <= watchdog_enable;
         MODULE_PIN_OE <= pwm_mode | (toggle_enable & compare_enable);
      end
   end

   assign MODULE_PIN_OUT = pin_out_reg;

endmodule // counter_array_capture_pwm

// ===== rtl/counter_array_pkg.sv
package counter_array_pkg;

   // ***********************************************
   // Register addresses (special-function space)
   // ***********************************************
   localparam logic [7:0] ADDR_MODULE_MODE = 8'hDE;
   localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'hD8;
   localparam logic [7:0] ADDR_COUNTER_MODE = 8'hD9;
   localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hF9;
   localparam logic [7:0] ADDR_COUNTER_LOW = 8'hE9;
   localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'hFE;
   localparam logic [7:0] ADDR_CAPTURE_LOW = 8'hEE;

   // ***********************************************
   // Field positions
   // ***********************************************
   // counter_mode
   localparam int IDLE_STOP_BIT = 7;
   localparam int WATCHDOG_ENABLE_BIT = 6;
   localparam int TICK_SELECT_HI_BIT = 2;
   localparam int TICK_SELECT_LO_BIT = 1;
   localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;
   // counter_control
   localparam int OVERFLOW_FLAG_BIT = 7;
   localparam int RUN_BIT = 6;
   localparam int MODULE_EVENT_FLAG_BIT = 4;
   // module_mode
   localparam int COMPARE_ENABLE_BIT = 6;
   localparam int CAPTURE_RISING_BIT = 5;
   localparam int CAPTURE_FALLING_BIT = 4;
   localparam int MATCH_FLAG_ENABLE_BIT = 3;
   localparam int TOGGLE_ENABLE_BIT = 2;
   localparam int PWM_ENABLE_BIT = 1;
   localparam int MODULE_IRQ_ENABLE_BIT = 0;

   // Implemented bits of each register
   localparam logic [7:0] COUNTER_MODE_MASK = 8'hC7;
   localparam logic [7:0] COUNTER_CONTROL_MASK = 8'hD0;
   localparam logic [7:0] MODULE_MODE_MASK = 8'h7F;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [7:0] COUNTER_MODE_RESET = 8'h00;
   localparam logic [7:0] COUNTER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODULE_MODE_RESET = 8'h00;
   localparam logic [15:0] COUNTER_RESET = 16'h0000;
   localparam logic [15:0] CAPTURE_RESET = 16'h0000;

   // ***********************************************
   // Tick sources and prescale
   // ***********************************************
   typedef enum logic [1:0] {
      TICK_DIV12 = 2'b00,
      TICK_DIV4 = 2'b01,
      TICK_TIMER0 = 2'b10,
      TICK_PIN = 2'b11
   } tick_source_t;

   localparam int OSC_DIV_SLOW = 12;
   localparam int OSC_DIV_FAST = 4;
   localparam logic [3:0] PRESCALE_LAST = 4'(OSC_DIV_SLOW - 1);
   localparam logic [7:0] LOW_BYTE_ALL_ONES = 8'hFF;

endpackage

// ===== rtl/pin_edge_detect.sv
`timescale 1ns/10ps
// Two-flop synchroniser followed by edge detection
module pin_edge_detect (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // ***********************************************
   // Synchroniser and history
   // ***********************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Edge decode on the settled copies only
   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;

endmodule // pin_edge_detect

// ===== rtl/tick_prescaler.sv
`timescale 1ns/10ps
// Produces one-cycle ticks at osc/12 and osc/4
module tick_prescaler (
   input wire logic clk,
   input wire logic arst_n,
   output logic tick_div12,
   output logic tick_div4
);

   logic [3:0] count_reg;
   logic [3:0] count_next;

   // ***********************************************
   // Free-running modulo-12 counter
   // ***********************************************
   assign count_next = (count_reg == counter_array_pkg::PRESCALE_LAST) ?
                       4'h0 : count_reg + 4'h1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= 4'h0;
      end else begin
         count_reg <= count_next;
      end
   end

   // Strobe decode; 12 is a multiple of 4 so both stay aligned
   assign tick_div12 = (count_reg == counter_array_pkg::PRESCALE_LAST);
   assign tick_div4 = (count_reg[1:0] == 2'(counter_array_pkg::OSC_DIV_FAST - 1));

endmodule // tick_prescaler

// ===== tb/counter_array_checker_assertions.sv
`timescale 1ns/10ps
// ******************************************
// Register port and status output checks
// ******************************************
module counter_array_checker (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_RDATA,
   input wire logic MODULE_PIN_OE,
   input wire logic IRQ,
   input wire logic WATCHDOG_ACTIVE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   // Addresses that hold a register
   wire mapped = SFR_ADDR inside {8'hD8, 8'hD9, 8'hDE, 8'hF9, 8'hE9,
      8'hFE, 8'hEE};

   // Address held with no write taken
   sequence s_hold(a);
      SFR_ADDR == a && !SFR_WR;
   endsequence

   property p_unmapped;
      !mapped |=> SFR_RDATA == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped address read not zero");

   property p_ctrl_bits;
      SFR_ADDR == 8'hD8 |=> (SFR_RDATA & 8'h2F) == 8'h00;
   endproperty
   a_ctrl_bits: assert property (p_ctrl_bits)
      else $error("Control spare bits not zero");

   property p_mode_bits;
      SFR_ADDR == 8'hD9 |=> (SFR_RDATA & 8'h38) == 8'h00;
   endproperty
   a_mode_bits: assert property (p_mode_bits)
      else $error("Counter mode spare bits not zero");

   property p_ovf_sticky;
      s_hold(8'hD8) ##1 (SFR_ADDR == 8'hD8 && SFR_RDATA[7]) |=> SFR_RDATA[7];
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky)
      else $error("Overflow flag dropped without write");

   property p_evt_sticky;
      s_hold(8'hD8) ##1 (SFR_ADDR == 8'hD8 && SFR_RDATA[4]) |=> SFR_RDATA[4];
   endproperty
   a_evt_sticky: assert property (p_evt_sticky)
      else $error("Event flag dropped without write");

   property p_irq_fall;
      $fell(IRQ) |-> $past(SFR_WR);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("Interrupt fell without write");

   property p_oe_mode;
      s_hold(8'hDE) [*3] |-> MODULE_PIN_OE ==
         (SFR_RDATA[6] && (SFR_RDATA[1] || SFR_RDATA[2]));
   endproperty
   a_oe_mode: assert property (p_oe_mode)
      else $error("Pin enable does not match mode");

   property p_wd_change;
      $changed(WATCHDOG_ACTIVE) |-> $past(SFR_WR) || $past(SFR_WR, 2);
   endproperty
   a_wd_change: assert property (p_wd_change)
      else $error("Watchdog level moved without write");

   property p_wd_val;
      s_hold(8'hD9) [*3] |-> WATCHDOG_ACTIVE == SFR_RDATA[6];
   endproperty
   a_wd_val: assert property (p_wd_val)
      else $error("Watchdog level differs from mode bit");
endmodule // counter_array_checker

// ===== tb/ext_pins.sv
`timescale 1ns/10ps
// ******************************************
// External count pin and module pin
// ******************************************
module ext_pins (
   input wire logic clk,
   output logic count_pin,
   output logic module_pin
);
   // Both pins idle low
   initial begin
      count_pin = 1'b0;
      module_pin = 1'b0;
   end

   // One count pulse, four cycles high then four low
   task automatic pulse();
      @(posedge clk);
      count_pin <= 1'b1;
      repeat (4) @(posedge clk);
      count_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // New module pin level, then time for the synchroniser
   task automatic level(input logic l);
      @(posedge clk);
      module_pin <= l;
      repeat (6) @(posedge clk);
   endtask
endmodule // ext_pins

// ===== tb/test_counter_array_capture_pwm.sv
`timescale 1ns/10ps
// ******************************************
// Bench top
// ******************************************
module test_counter_array_capture_pwm;
   logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, idle = 1'b0, t0 = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
   logic pin_cnt, pin_mod, pout, poe, irq, wdog;
   int fails = 0, checks_done = 0, i;
   logic [7:0] regs [7] = '{8'hD8, 8'hD9, 8'hDE, 8'hF9, 8'hE9, 8'hFE, 8'hEE};
   logic [7:0] cm [3] = '{8'h20, 8'h10, 8'h30};

   initial forever #10 clk = ~clk;

   counter_array_capture_pwm u_dut (.CLK(clk), .ARST_N(arst_n),
      .SFR_ADDR(addr), .SFR_WDATA(wd), .SFR_WR(wr), .SFR_RDATA(rdata),
      .CPU_IDLE(idle), .TIMER0_OVERFLOW(t0), .COUNT_INPUT_PIN(pin_cnt),
      .MODULE_PIN_IN(pin_mod), .MODULE_PIN_OUT(pout), .MODULE_PIN_OE(poe),
      .IRQ(irq), .WATCHDOG_ACTIVE(wdog));
   ext_pins u_pins (.clk(clk), .count_pin(pin_cnt), .module_pin(pin_mod));

   // Bus cycles, compare and verdict
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      repeat (3) @(posedge clk);
      #1 d = rdata;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd8(a, d);
      cmp8(d, e);
   endtask
   task automatic t0p(input int n);
      repeat (n) begin
         @(posedge clk);
         t0 <= 1'b1;
         @(posedge clk);
         t0 <= 1'b0;
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard
   initial begin
      #1500000;
      fails++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      foreach (regs[k]) chk(regs[k], 8'h00);
      wr8(8'h00, 8'hFF);
      chk(8'h00, 8'h00);
      wr8(8'hD9, 8'hFF);
      chk(8'hD9, 8'hC7);
      cmp8({7'h00, wdog}, 8'h01);
      wr8(8'hD9, 8'h00);
      chk(8'hD9, 8'h00);
      cmp8({7'h00, wdog}, 8'h00);
      for (i = 0; i < 2; i++) begin
         wr8(8'hE9, 8'h00);
         wr8(8'hD9, 8'(i * 2));
         wr8(8'hD8, 8'h40);
         repeat (120) @(posedge clk);
         wr8(8'hD8, 8'h00);
         rd8(8'hE9, v);
         cmp8((v == 8'(10 + 20 * i + 1)) ? v - 8'h01 : v, 8'(10 + 20 * i));
      end
      wr8(8'hE9, 8'h00);
      wr8(8'hD9, 8'h04);
      wr8(8'hD8, 8'h40);
      t0p(5);
      wr8(8'hD8, 8'h00);
      t0p(2);
      chk(8'hE9, 8'h05);
      wr8(8'hE9, 8'h00);
      wr8(8'hD9, 8'h06);
      wr8(8'hD8, 8'h40);
      repeat (3) u_pins.pulse();
      wr8(8'hD8, 8'h00);
      chk(8'hE9, 8'h03);
      wr8(8'hE9, 8'h00);
      wr8(8'hD9, 8'h84);
      wr8(8'hD8, 8'h40);
      idle <= 1'b1;
      t0p(3);
      chk(8'hE9, 8'h00);
      wr8(8'hD9, 8'h04);
      t0p(2);
      chk(8'hE9, 8'h02);
      idle <= 1'b0;
      wr8(8'hD8, 8'h00);
      wr8(8'hF9, 8'hFF);
      wr8(8'hE9, 8'hFF);
      wr8(8'hD9, 8'h05);
      wr8(8'hD8, 8'h40);
      t0p(1);
      chk(8'hF9, 8'h00);
      chk(8'hD8, 8'hC0);
      cmp8({7'h00, irq}, 8'h01);
      t0p(1);
      chk(8'hD8, 8'hC0);
      wr8(8'hD8, 8'h40);
      chk(8'hD8, 8'h40);
      cmp8({7'h00, irq}, 8'h00);
      wr8(8'hD9, 8'h04);
      for (i = 0; i < 3; i++) begin
         wr8(8'hD8, 8'h00);
         wr8(8'hE9, 8'h00);
         wr8(8'hF9, 8'h00);
         wr8(8'hFE, 8'h00);
         wr8(8'hEE, 8'h05);
         wr8(8'hDE, i == 0 ? 8'h49 : i == 1 ? 8'h09 : 8'h4C);
         wr8(8'hD8, 8'h40);
         t0p(5);
         #1 v = {7'h00, pout};
         t0p(1);
         chk(8'hD8, i == 1 ? 8'h40 : 8'h50);
         cmp8({7'h00, irq}, i == 0 ? 8'h01 : 8'h00);
         cmp8({7'h00, pout}, i == 2 ? v ^ 8'h01 : v);
      end
      wr8(8'hD8, 8'h00);
      for (i = 0; i < 3; i++) begin
         wr8(8'hFE, 8'h00);
         wr8(8'hEE, 8'h00);
         wr8(8'hF9, 8'h12);
         wr8(8'hE9, 8'h34);
         wr8(8'hDE, cm[i]);
         wr8(8'hD8, 8'h00);
         u_pins.level(1'b1);
         wr8(8'hF9, 8'h56);
         wr8(8'hE9, 8'h78);
         u_pins.level(1'b0);
         chk(8'hFE, i == 0 ? 8'h12 : 8'h56);
         chk(8'hEE, i == 0 ? 8'h34 : 8'h78);
         chk(8'hD8, 8'h10);
      end
      wr8(8'hDE, 8'h42);
      wr8(8'hEE, 8'h80);
      wr8(8'hFE, 8'h40);
      for (i = 0; i < 2; i++) begin
         wr8(8'hE9, 8'h7F + 8'(i));
         chk(8'hE9, 8'h7F + 8'(i));
         cmp8({6'h00, poe, pout}, 8'h02 + 8'(i));
      end
      wr8(8'hE9, 8'hFF);
      wr8(8'hD8, 8'h40);
      t0p(1);
      wr8(8'hD8, 8'h00);
      chk(8'hEE, 8'h40);
      for (i = 0; i < 2; i++) begin
         wr8(8'hE9, 8'h3F + 8'(i));
         chk(8'hE9, 8'h3F + 8'(i));
         cmp8({7'h00, pout}, 8'(i));
      end
      give_verdict();
   end
endmodule // test_counter_array_capture_pwm

bind counter_array_capture_pwm counter_array_checker u_chk (.CLK(CLK),
   .ARST_N(ARST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
   .SFR_RDATA(SFR_RDATA), .MODULE_PIN_OE(MODULE_PIN_OE), .IRQ(IRQ),
   .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE));
